//--- bench/tb.sv
// Self-checking bench for the video output block
`timescale 1ns/1ps
module tb;
   logic        clk, rst_n, pll_locked, payload_error, power_down_n;
   logic        output_enable_pin, self_test_enable, interrupt_input;
   logic        px_in_valid, px_in_ready, reg_wr, reg_rd, pm, pb, m18;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, cnt;
   logic [23:0] rgb_out, rgb_oe_n;
   logic        line_sync, frame_sync, pixel_valid, pixel_clk_out;
   logic        ctl_oe_n, audio_bit_clk, audio_word_select;
   logic        audio_data_first, audio_master_clk, audio_oe_n;
   logic        lock, pass, self_test_active, clock_recovery_en;
   logic [15:0] frames, words;
   int          bad_count, checks, i, m, n, b;
   vpi_out u_dut (.clk, .rst_n, .px_in_valid, .px_in_ready,
      .px_in_rgb(cnt[23:0]), .px_in_line_sync(cnt[7]),
      .px_in_frame_sync(cnt[8]), .px_in_pixel_valid(~cnt[7]),
      .aud_in_a(cnt[0]), .aud_in_b(cnt[1]), .pll_locked, .payload_error,
      .power_down_n, .output_enable_pin, .output_sleep_select(1'b0),
      .mode_sel_18bit(m18), .self_test_enable, .interrupt_input,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rgb_out,
      .rgb_oe_n, .rgb_pin_in(rgb_out), .line_sync, .frame_sync,
      .pixel_valid, .pixel_clk_out, .ctl_oe_n, .audio_bit_clk,
      .audio_word_select, .audio_data_first, .audio_master_clk,
      .audio_oe_n, .lock, .pass, .self_test_active, .clock_recovery_en);
   vpi_disp_model u_disp (.pixel_clk_out, .frame_sync, .pixel_valid,
      .frames, .words);
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   // Word counter doubles as pixel data, so sync widths stay legal
   always @(posedge clk) begin
      if (!rst_n) begin
         cnt <= 32'h0;
      end else if (px_in_valid && px_in_ready) begin
         cnt <= cnt + 32'h1;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] k, e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata & k, e);
   endtask
   task automatic results;
      $display("checks=%0d mismatches=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (10000) @(posedge clk);
      bad_count++;
      results;
   end
   initial begin
      {rst_n, pll_locked, payload_error, power_down_n, px_in_valid} = '0;
      {self_test_enable, interrupt_input, reg_wr, reg_rd, m18} = '0;
      {reg_addr, reg_wdata} = '0;
      output_enable_pin = 1'b1;
      bad_count = 0;
      checks = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      cyc(3);
      chk(rgb_oe_n, 24'hFFFFFF);
      chk({ctl_oe_n, audio_oe_n, clock_recovery_en}, 3'h6);
      rd(4'h0, 32'hFFFFFFFF, 32'h002);
      rd(4'h4, 32'hFFFFFFFF, 32'h0);
      rd(4'h2, 32'hFFFFFFFF, 32'h0);
      // Link down: nothing drains, so the ninth word must be refused
      px_in_valid <= 1'b1;
      cyc(15);
      chk(px_in_ready, 0);
      chk(cnt, 8);
      rd(4'hC, 32'h80, 32'h80);
      power_down_n    <= 1'b1;
      pll_locked      <= 1'b1;
      interrupt_input <= 1'b1;
      for (i = 0; i < 40 && lock !== 1'b1; i++) @(posedge clk);
      chk(lock, 1);
      rd(4'hC, 32'h103, 32'h103);
      cyc(1500);
      chk(frames != 16'h0 && words != 16'h0, 1);
      payload_error <= 1'b1;
      cyc(1);
      payload_error <= 1'b0;
      cyc(2);
      chk(pass, 0);
      // 18-bit mode from the pin this time, the register bit stays clear
      m18 <= 1'b1;
      wr(4'h0, 32'h3A2);
      wr(4'h4, 32'h1F);
      wr(4'h8, 32'hFF);
      cyc(3);
      chk({rgb_out[17:16], rgb_out[9:8], rgb_out[1:0]}, 6'h3F);
      chk({rgb_oe_n[17:16], rgb_oe_n[9:8]}, 4'h0);
      chk({audio_bit_clk, audio_word_select, audio_data_first}, 3'h7);
      wr(4'h4, 32'h0);
      wr(4'h8, 32'h0F);
      cyc(3);
      chk({rgb_out[1:0], audio_bit_clk, audio_word_select}, 4'h0);
      chk({rgb_oe_n[17:16], rgb_oe_n[9:8]}, 4'hF);
      for (b = 0; b < 3; b++) begin
         wr(4'h0, {28'h0, b[1:0], 2'h2});
         cyc(1);
         m = 0;
         n = 0;
         repeat (64) begin
            pm = audio_master_clk;
            pb = audio_bit_clk;
            cyc(1);
            m += int'(audio_master_clk && !pm);
            n += int'(audio_bit_clk && !pb);
         end
         chk(n, 8);
         chk(m, n << b);
      end
      self_test_enable <= 1'b1;
      cyc(2);
      chk(self_test_active, 1);
      rd(4'hC, 32'h200, 32'h200);
      power_down_n <= 1'b0;
      cyc(4);
      chk({ctl_oe_n, audio_oe_n, pass, clock_recovery_en}, 4'hE);
      chk(rgb_oe_n, 24'hFFFFFF);
      results;
   end
endmodule

//--- bench/vpi_disp_model.sv
// Display timing controller model at the parallel pins
`timescale 1ns/1ps
module vpi_disp_model (
   // Pins from the block
   input wire logic        pixel_clk_out,
   input wire logic        frame_sync,
   input wire logic        pixel_valid,
   // Tallies
   output logic [15:0]     frames,
   output logic [15:0]     words
);
   logic fs_prev;
   initial begin
      frames  = 16'h0000;
      words   = 16'h0000;
      fs_prev = 1'b0;
   end
   // At the reset edge select data launch with the rising strobe, so the
   // pins are taken on the falling one, half a pixel later
   always @(negedge pixel_clk_out) begin
      if (frame_sync && !fs_prev) begin
         frames <= frames + 16'h0001;
      end
      if (pixel_valid) begin
         words <= words + 16'h0001;
      end
      fs_prev <= frame_sync;
   end
endmodule

//--- bench/vpi_out_assertions.sv
// Port checker for the video output block
`timescale 1ns/1ps
module vpi_out_chk (
   // Watched ports
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        power_down_n,
   input wire logic        pll_locked,
   input wire logic        payload_error,
   input wire logic        self_test_enable,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [23:0] rgb_oe_n,
   input wire logic        ctl_oe_n,
   input wire logic        pixel_clk_out,
   input wire logic        frame_sync,
   input wire logic        lock,
   input wire logic        pass,
   input wire logic        self_test_active,
   input wire logic        clock_recovery_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic       fs_last_r;
   logic [8:0] fs_age_r, fs_age_nxt;
   // Saturates so a long quiet spell never wraps into a false short one
   always_comb begin
      fs_age_nxt = (fs_age_r == 9'h1FF) ? fs_age_r : fs_age_r + 9'h001;
      if (frame_sync != fs_last_r) begin
         fs_age_nxt = 9'h000;
      end
   end
   always_ff @(posedge clk) begin
      fs_last_r <= rst_n ? frame_sync : 1'b0;
      fs_age_r  <= rst_n ? fs_age_nxt : 9'h1FF;
   end
   a_pd_tristate: assert property (!power_down_n [*3] |->
      ctl_oe_n && (&rgb_oe_n) && !pixel_clk_out) else $error("pd out");
   a_recov_en: assert property (clock_recovery_en == power_down_n)
      else $error("recovery enable");
   a_self_test: assert property (self_test_active == self_test_enable)
      else $error("self test");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("rdata idle");
   a_fs_rate: assert property (power_down_n && frame_sync != fs_last_r
      |-> fs_age_r >= 9'h103) else $error("frame sync rate");
   a_pass_drop: assert property (lock && pll_locked && power_down_n
      && payload_error |=> !pass) else $error("pass drop");
   a_pass_rearm: assert property (!power_down_n [*2] |=> pass)
      else $error("pass rearm");
   a_lock_cause: assert property (!pll_locked [*3] |-> !lock)
      else $error("lock");
   cover property ($rose(lock));
   cover property ($fell(pass));
   cover property (frame_sync != fs_last_r);
endmodule
bind vpi_out vpi_out_chk u_chk (.clk, .rst_n, .power_down_n, .pll_locked,
   .payload_error, .self_test_enable, .reg_rd, .reg_rdata, .rgb_oe_n,
   .ctl_oe_n, .pixel_clk_out, .frame_sync, .lock, .pass, .self_test_active,
   .clock_recovery_en);

//--- core/vpi_ctrl_filt.sv
// Minimum pulse filter and transition rate limiter for one video control line
`timescale 1ns/1ps
`include "vpi_params.svh"
module vpi_ctrl_filt #(
   parameter int MAX_TR = 2
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control
   input  wire logic tick,
   input  wire logic filt_en,
   // Level in and out
   input  wire logic din,
   output logic      dout
);
   logic       in_r;
   logic       in_nxt;
   logic [1:0] stab_r;
   logic [1:0] stab_nxt;
   logic       out_r;
   logic       out_nxt;
   logic [7:0] age0_r;
   logic [7:0] age0_nxt;
   logic [7:0] age1_r;
   logic [7:0] age1_nxt;
   logic       cand;
   logic       allow;

   assign dout = out_r;

   always_comb begin
      in_nxt   = in_r;
      stab_nxt = stab_r;
      out_nxt  = out_r;
      age0_nxt = age0_r;
      age1_nxt = age1_r;
      // Short pulses are dropped only while filtering
      cand = (!filt_en || stab_r >= `VPI_FILT_MIN) ? in_r : out_r;
      allow = (MAX_TR == 1) ? (age0_r >= `VPI_TR_WIN)
                            : (age1_r >= `VPI_TR_WIN);
      if (tick) begin
         in_nxt = din;
         if (din != in_r) begin
            stab_nxt = 2'h1;
         end else if (stab_r != `VPI_FILT_MIN) begin
            stab_nxt = stab_r + 2'h1;
         end
         if (age0_r != `VPI_AGE_MAX) begin
            age0_nxt = age0_r + 8'h01;
         end
         if (age1_r != `VPI_AGE_MAX) begin
            age1_nxt = age1_r + 8'h01;
         end
         // A change held back is taken once allowed, but only if the input still holds it then
         if (cand != out_r && allow) begin
            out_nxt  = cand;
            age1_nxt = age0_r;
            age0_nxt = 8'h00;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         in_r   <= 1'b0;
         stab_r <= 2'h0;
         out_r  <= 1'b0;
         age0_r <= `VPI_AGE_MAX;
         age1_r <= `VPI_AGE_MAX;
      end else begin
         in_r   <= in_nxt;
         stab_r <= stab_nxt;
         out_r  <= out_nxt;
         age0_r <= age0_nxt;
         age1_r <= age1_nxt;
      end
   end
endmodule

//--- core/vpi_fifo.sv
// Pixel word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module vpi_fifo #(
   parameter int W = 27,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW:0]  wp_r;
   logic [AW:0]  wp_nxt;
   logic [AW:0]  rp_r;
   logic [AW:0]  rp_nxt;
   logic         full;
   logic         empty;

   // Extra pointer bit tells full from empty
   assign empty     = (wp_r == rp_r);
   assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rp_r[AW-1:0]];

   always_comb begin
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      if (in_valid && !full) begin
         wp_nxt = wp_r + (AW+1)'(1);
      end
      if (out_ready && !empty) begin
         rp_nxt = rp_r + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   // Storage needs no reset, only pointers do
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end
endmodule

//--- core/vpi_out.sv
// Parallel video and audio output side with shared pin functions
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "vpi_params.svh"
module vpi_out (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Recovered pixel stream
   input  wire logic                   px_in_valid,
   output logic                        px_in_ready,
   input  wire logic [23:0]            px_in_rgb,
   input  wire logic                   px_in_line_sync,
   input  wire logic                   px_in_frame_sync,
   input  wire logic                   px_in_pixel_valid,
   // Recovered audio bits
   input  wire logic                   aud_in_a,
   input  wire logic                   aud_in_b,
   // Link status
   input  wire logic                   pll_locked,
   input  wire logic                   payload_error,
   // Control pins
   input  wire logic                   power_down_n,
   input  wire logic                   output_enable_pin,
   input  wire logic                   output_sleep_select,
   input  wire logic                   mode_sel_18bit,
   input  wire logic                   self_test_enable,
   input  wire logic                   interrupt_input,
   // Register port
   input  wire logic [`VPI_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata,
   // Colour pins, R in 23:16, G in 15:8, B in 7:0
   output logic [23:0]                 rgb_out,
   output logic [23:0]                 rgb_oe_n,
   input  wire logic [23:0]            rgb_pin_in,
   // Video control pins
   output logic                        line_sync,
   output logic                        frame_sync,
   output logic                        pixel_valid,
   output logic                        pixel_clk_out,
   output logic                        ctl_oe_n,
   // Audio pins
   output logic                        audio_bit_clk,
   output logic                        audio_word_select,
   output logic                        audio_data_first,
   output logic                        audio_master_clk,
   output logic                        audio_oe_n,
   // Status pins
   output logic                        lock,
   output logic                        pass,
   output logic                        self_test_active,
   output logic                        clock_recovery_en
);
   logic [`VPI_CFG_W-1:0]  cfg_r;
   logic [`VPI_CFG_W-1:0]  cfg_nxt;
   logic [`VPI_GPO_W-1:0]  gpo_r;
   logic [`VPI_GPO_W-1:0]  gpo_nxt;
   logic [`VPI_GPIO_W-1:0] gpio_r;
   logic [`VPI_GPIO_W-1:0] gpio_nxt;
   logic [31:0]            rdata_r;
   logic [31:0]            rdata_nxt;
   logic                   strap_done_r;
   logic                   strap_oen_r;
   logic                   strap_oss_r;
   logic                   pclk_r;
   logic                   pclk_nxt;
   logic                   tick;
   vpi_pkg::vpi_out_st_t   st_r;
   vpi_pkg::vpi_out_st_t   st_nxt;
   logic                   fifo_valid;
   logic                   fifo_ready;
   logic [`VPI_PIX_W-1:0]  fifo_data;
   logic [7:0]             pat_r;
   logic [7:0]             pat_nxt;
   logic [23:0]            rgb_a_r;
   logic [23:0]            rgb_b_r;
   logic [23:0]            rgb_c_r;
   logic [23:0]            rgb_a_nxt;
   logic [2:0]             ctl_a_r;
   logic [2:0]             ctl_a_nxt;
   logic                   ls_f;
   logic                   fs_f;
   logic                   pv_f;
   logic [2:0]             acnt_r;
   logic [2:0]             acnt_nxt;
   logic [3:0]             bitn_r;
   logic [3:0]             bitn_nxt;
   logic                   ws_r;
   logic                   ws_nxt;
   logic                   da_r;
   logic                   da_nxt;
   logic                   db_r;
   logic                   db_nxt;
   logic                   mclk_r;
   logic                   mclk_nxt;
   logic                   pass_r;
   logic                   pass_nxt;
   logic                   lock_r;
   logic [23:0]            orgb_r;
   logic [23:0]            orgb_nxt;
   logic [23:0]            ooe_r;
   logic [23:0]            ooe_nxt;
   logic [2:0]             octl_r;
   logic [2:0]             octl_nxt;
   logic [3:0]             oaud_r;
   logic [3:0]             oaud_nxt;
   logic                   octl_oe_r;
   logic                   octl_oe_nxt;
   logic                   mode18;
   logic                   gpio_mode;
   logic                   audb_mode;
   logic                   filt_en;

   assign mode18    = mode_sel_18bit | cfg_r[`VPI_CFG_MODE18];
   assign gpio_mode = mode18 & cfg_r[`VPI_CFG_GPIO];
   assign audb_mode = mode18 & cfg_r[`VPI_CFG_AUDB];
   assign filt_en   = cfg_r[`VPI_CFG_FILT];

   // Pixel clock out toggles every clock while live, else held low; data moves when it takes the
   // level picked by the edge select bit
   assign pclk_nxt = !pclk_r;
   assign tick     = (st_r == vpi_pkg::OUT_LIVE)
                     && (pclk_nxt == cfg_r[`VPI_CFG_EDGE]);
   // Drain stalls when not live, so the FIFO fills and stops the source
   assign fifo_ready = tick && !self_test_enable;

   vpi_fifo #(
      .W (`VPI_PIX_W),
      .D (`VPI_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (px_in_valid),
      .in_ready  (px_in_ready),
      .in_data   ({px_in_frame_sync, px_in_line_sync, px_in_pixel_valid,
                   px_in_rgb}),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready),
      .out_data  (fifo_data)
   );

   vpi_ctrl_filt #(.MAX_TR(2)) u_ls (
      .clk     (clk),
      .rst_n   (rst_n),
      .tick    (tick),
      .filt_en (filt_en),
      .din     (ctl_a_r[1]),
      .dout    (ls_f)
   );

   vpi_ctrl_filt #(.MAX_TR(2)) u_pv (
      .clk     (clk),
      .rst_n   (rst_n),
      .tick    (tick),
      .filt_en (filt_en),
      .din     (ctl_a_r[0]),
      .dout    (pv_f)
   );

   // Frame sync is never pulse filtered, only rate limited
   vpi_ctrl_filt #(.MAX_TR(1)) u_fs (
      .clk     (clk),
      .rst_n   (rst_n),
      .tick    (tick),
      .filt_en (1'b0),
      .din     (ctl_a_r[2]),
      .dout    (fs_f)
   );

   // Register port, output state and pixel path
   always_comb begin
      cfg_nxt   = cfg_r;
      gpo_nxt   = gpo_r;
      gpio_nxt  = gpio_r;
      rdata_nxt = 32'h0000_0000;
      if (reg_wr) begin
         unique case (reg_addr)
            `VPI_ADDR_CFG:  cfg_nxt  = reg_wdata[`VPI_CFG_W-1:0];
            `VPI_ADDR_GPO:  gpo_nxt  = reg_wdata[`VPI_GPO_W-1:0];
            `VPI_ADDR_GPIO: gpio_nxt = reg_wdata[`VPI_GPIO_W-1:0];
            default:        ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `VPI_ADDR_CFG:  rdata_nxt = {22'h0, cfg_r};
            `VPI_ADDR_GPO:  rdata_nxt = {27'h0, gpo_r};
            `VPI_ADDR_GPIO: rdata_nxt = {24'h0, gpio_r};
            `VPI_ADDR_STAT: rdata_nxt = {22'h0, self_test_enable,
                                          interrupt_input, !px_in_ready,
                                          rgb_pin_in[9], rgb_pin_in[8],
                                          rgb_pin_in[17], rgb_pin_in[16],
                                          mode18, pass_r, lock_r};
            default:        rdata_nxt = 32'h0000_0000;
         endcase
      end
      if (!power_down_n) begin
         st_nxt = vpi_pkg::OUT_OFF;
      end else if (!pll_locked) begin
         st_nxt = vpi_pkg::OUT_IDLE;
      end else begin
         st_nxt = vpi_pkg::OUT_LIVE;
      end
      rgb_a_nxt = rgb_a_r;
      ctl_a_nxt = ctl_a_r;
      pat_nxt   = pat_r;
      if (tick) begin
         if (self_test_enable) begin
            pat_nxt   = pat_r + 8'h01;
            rgb_a_nxt = {pat_r, ~pat_r, pat_r};
            ctl_a_nxt = 3'h1;
         end else if (fifo_valid) begin
            rgb_a_nxt = fifo_data[23:0];
            ctl_a_nxt = fifo_data[26:24];
         end else begin
            ctl_a_nxt = {ctl_a_r[2:1], 1'b0};
         end
      end
      // Pass drops on error and rearms when the link is lost
      pass_nxt = pass_r;
      if (st_r != vpi_pkg::OUT_LIVE) begin
         pass_nxt = 1'b1;
      end
      if (payload_error && st_r == vpi_pkg::OUT_LIVE) begin
         pass_nxt = 1'b0;
      end
   end

   // Audio clocks and serial data
   always_comb begin
      acnt_nxt = acnt_r;
      bitn_nxt = bitn_r;
      ws_nxt   = ws_r;
      da_nxt   = da_r;
      db_nxt   = db_r;
      if (st_r != vpi_pkg::OUT_OFF) begin
         acnt_nxt = acnt_r + 3'h1;
         // New bit on the falling bit clock edge
         if (acnt_r == 3'h7) begin
            bitn_nxt = bitn_r + 4'h1;
            da_nxt   = aud_in_a;
            db_nxt   = aud_in_b;
            if (bitn_r == `VPI_WORD_LAST) begin
               ws_nxt = !ws_r;
            end
         end
      end
      unique case (vpi_pkg::vpi_mclk_t'(cfg_r[`VPI_CFG_MCLK_HI:
                                               `VPI_CFG_MCLK_LO]))
         vpi_pkg::MCLK_X1: mclk_nxt = acnt_nxt[2];
         vpi_pkg::MCLK_X2: mclk_nxt = acnt_nxt[1];
         vpi_pkg::MCLK_X4: mclk_nxt = acnt_nxt[0];
         default:          mclk_nxt = acnt_nxt[2];
      endcase
   end

   // Pin assembly: drive state first, shared functions laid over it
   always_comb begin
      orgb_nxt    = rgb_c_r;
      octl_nxt    = {fs_f, ls_f, pv_f};
      oaud_nxt    = {acnt_nxt[2], ws_nxt, da_nxt, db_nxt};
      ooe_nxt     = 24'h00_0000;
      octl_oe_nxt = 1'b0;
      unique case (st_r)
         vpi_pkg::OUT_OFF: begin
            orgb_nxt    = 24'h00_0000;
            octl_nxt    = 3'h0;
            oaud_nxt    = 4'h0;
            ooe_nxt     = 24'hFF_FFFF;
            octl_oe_nxt = 1'b1;
         end
         vpi_pkg::OUT_IDLE: begin
            // Sleep select keeps the last level, else drive low
            orgb_nxt    = strap_oss_r ? orgb_r : 24'h00_0000;
            octl_nxt    = strap_oss_r ? octl_r : 3'h0;
            oaud_nxt    = strap_oss_r ? oaud_r : 4'h0;
            ooe_nxt     = {24{!strap_oen_r}};
            octl_oe_nxt = !strap_oen_r;
         end
         vpi_pkg::OUT_LIVE: ;
      endcase
      if (st_r != vpi_pkg::OUT_OFF) begin
         if (gpio_mode) begin
            orgb_nxt[16] = gpio_r[0];
            orgb_nxt[17] = gpio_r[1];
            orgb_nxt[8]  = gpio_r[2];
            orgb_nxt[9]  = gpio_r[3];
            ooe_nxt[16]  = !gpio_r[4];
            ooe_nxt[17]  = !gpio_r[5];
            ooe_nxt[8]   = !gpio_r[6];
            ooe_nxt[9]   = !gpio_r[7];
         end
         if (cfg_r[`VPI_CFG_GPO4]) begin
            orgb_nxt[0] = gpo_r[0];
            ooe_nxt[0]  = 1'b0;
         end
         if (audb_mode) begin
            orgb_nxt[1] = oaud_nxt[0];
            ooe_nxt[1]  = 1'b0;
         end else if (cfg_r[`VPI_CFG_GPO5]) begin
            orgb_nxt[1] = gpo_r[1];
            ooe_nxt[1]  = 1'b0;
         end
         if (cfg_r[`VPI_CFG_GPOAUD]) begin
            oaud_nxt[3:1] = gpo_r[4:2];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_r     <= `VPI_CFG_RST;
         gpo_r     <= `VPI_GPO_RST;
         gpio_r    <= `VPI_GPIO_RST;
         rdata_r   <= 32'h0000_0000;
         st_r      <= vpi_pkg::OUT_OFF;
         pclk_r    <= 1'b0;
         pat_r     <= 8'h00;
         rgb_a_r   <= 24'h00_0000;
         rgb_b_r   <= 24'h00_0000;
         rgb_c_r   <= 24'h00_0000;
         ctl_a_r   <= 3'h0;
         acnt_r    <= 3'h0;
         bitn_r    <= 4'h0;
         ws_r      <= 1'b0;
         da_r      <= 1'b0;
         db_r      <= 1'b0;
         mclk_r    <= 1'b0;
         pass_r    <= 1'b1;
         lock_r    <= 1'b0;
         orgb_r    <= 24'h00_0000;
         ooe_r     <= 24'hFF_FFFF;
         octl_r    <= 3'h0;
         oaud_r    <= 4'h0;
         octl_oe_r <= 1'b1;
      end else begin
         cfg_r     <= cfg_nxt;
         gpo_r     <= gpo_nxt;
         gpio_r    <= gpio_nxt;
         rdata_r   <= rdata_nxt;
         st_r      <= st_nxt;
         pclk_r    <= (st_r == vpi_pkg::OUT_LIVE) ? pclk_nxt : 1'b0;
         pat_r     <= pat_nxt;
         rgb_a_r   <= rgb_a_nxt;
         // Colour follows the two-stage control filter latency
         rgb_b_r   <= tick ? rgb_a_r : rgb_b_r;
         rgb_c_r   <= tick ? rgb_b_r : rgb_c_r;
         ctl_a_r   <= ctl_a_nxt;
         acnt_r    <= acnt_nxt;
         bitn_r    <= bitn_nxt;
         ws_r      <= ws_nxt;
         da_r      <= da_nxt;
         db_r      <= db_nxt;
         mclk_r    <= (st_r == vpi_pkg::OUT_OFF) ? 1'b0 : mclk_nxt;
         pass_r    <= pass_nxt;
         lock_r    <= (st_nxt == vpi_pkg::OUT_LIVE);
         orgb_r    <= orgb_nxt;
         ooe_r     <= ooe_nxt;
         octl_r    <= octl_nxt;
         oaud_r    <= oaud_nxt;
         octl_oe_r <= octl_oe_nxt;
      end
   end

   // Straps are caught once, on the first edge after reset release
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strap_done_r <= 1'b0;
         strap_oen_r  <= 1'b0;
         strap_oss_r  <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         strap_oen_r  <= output_enable_pin;
         strap_oss_r  <= output_sleep_select;
      end
   end

   assign reg_rdata         = rdata_r;
   assign rgb_out           = orgb_r;
   assign rgb_oe_n          = ooe_r;
   assign frame_sync        = octl_r[2];
   assign line_sync         = octl_r[1];
   assign pixel_valid       = octl_r[0];
   assign ctl_oe_n          = octl_oe_r;
   assign pixel_clk_out     = pclk_r;
   assign audio_bit_clk     = oaud_r[3];
   assign audio_word_select = oaud_r[2];
   assign audio_data_first  = oaud_r[1];
   assign audio_master_clk  = mclk_r;
   assign audio_oe_n        = octl_oe_r;
   assign lock              = lock_r;
   assign pass              = pass_r;
   assign self_test_active  = self_test_enable;
   assign clock_recovery_en = power_down_n;
endmodule

//--- core/vpi_params.svh
// Register offsets, field positions, reset values and counts of the video output block
`ifndef VPI_PARAMS_SVH
`define VPI_PARAMS_SVH

`define VPI_ADDR_W       4
`define VPI_ADDR_CFG     4'h0
`define VPI_ADDR_GPO     4'h4
`define VPI_ADDR_GPIO    4'h8
`define VPI_ADDR_STAT    4'hC

`define VPI_CFG_W        10
`define VPI_CFG_RST      10'h002
`define VPI_CFG_EDGE     0
`define VPI_CFG_FILT     1
`define VPI_CFG_MCLK_LO  2
`define VPI_CFG_MCLK_HI  3
`define VPI_CFG_MODE18   4
`define VPI_CFG_GPIO     5
`define VPI_CFG_AUDB     6
`define VPI_CFG_GPO4     7
`define VPI_CFG_GPO5     8
`define VPI_CFG_GPOAUD   9

`define VPI_GPO_W        5
`define VPI_GPO_RST      5'h00
`define VPI_GPIO_W       8
`define VPI_GPIO_RST     8'h00

`define VPI_PIX_W        27
`define VPI_FIFO_DEPTH   8

`define VPI_FILT_MIN     2'h3
`define VPI_TR_WIN       8'h82
`define VPI_AGE_MAX      8'hFF
`define VPI_WORD_LAST    4'hF

`endif

//--- core/vpi_pkg.sv
// Types shared by the video output block
package vpi_pkg;
   typedef enum logic [1:0] {MCLK_X1, MCLK_X2, MCLK_X4} vpi_mclk_t;
   typedef enum logic [1:0] {OUT_OFF, OUT_IDLE, OUT_LIVE} vpi_out_st_t;
endpackage
